// [src/sdr_pkg.sv]
// Package with constants shared by the result-ready port of the converter.
package sdr_pkg;
    // Width of one conversion result word.
    localparam int RESULT_W = 16;
    // Master-clock periods for which result-ready goes high ahead of an unread update.
    localparam int PRE_UPDATE_MCLK = 500;
    // Width of the master-clock period counter.
    localparam int MCLK_CNT_W = 10;
    // Core clock period in picoseconds (40 MHz).
    localparam int CORE_PERIOD_PS = 25000;
    // Reset value of the shift counter.
    localparam logic [4:0] BIT_CNT_RST = 5'h00;
    // Reset value of the result data register.
    localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage : sdr_pkg

// [src/sdr_ready_port.sv]
// Result-ready pacing, serial result shift-out and master-clock forwarding.
//
// How it works
// - Drive result_ready_n low when a fresh result waits in the data register.
// - Return result_ready_n high once the host shifts out a whole word.
// - Unread result: hold result_ready_n high 500 master clocks before update.
// - Drive result_ready_n low again once the data register is updated.
// - Calibration completion is also signalled by result_ready_n going low.
// - Master clock output is the inverse of the master clock input.
// - Master clock output enable is low while clock_output_disable is set; the inverted clock keeps running.
// - Reset pin is active low and resets the device.
// - Each conversion result is a 16-bit word.
`timescale 1ns/100ps
module sdr_ready_port
    import sdr_pkg::*;
#(
    parameter int RESULT_WIDTH = sdr_pkg::RESULT_W,
    parameter int PRE_UPDATE_PERIODS = sdr_pkg::PRE_UPDATE_MCLK
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_reset_n_pin,
    input wire logic i_mclk_in,
    input wire logic i_clock_output_disable,
    input wire logic i_result_valid,
    input wire logic [RESULT_WIDTH-1:0] i_result,
    input wire logic i_cal_done,
    input wire logic i_serial_clk,
    input wire logic i_chip_select_n,
    output logic o_mclk_out,
    output logic o_mclk_out_en,
    output logic o_result_ready_n,
    output logic o_serial_out,
    output logic o_serial_out_en,
    output logic o_update_pending
);
    import sdr_pkg::*;

    // Port-side states of the ready flag.
    typedef enum logic [2:0] {
        SDR_IDLE = 3'b001,
        SDR_READY = 3'b010,
        SDR_HOLD = 3'b100
    } sdr_state_e;

    sdr_state_e state;
    sdr_state_e next_state;
    logic rst_pin_s1;
    logic rst_pin_s2;
    logic soft_reset;
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_s3;
    logic mclk_rise;
    logic [MCLK_CNT_W-1:0] hold_cnt;
    logic [RESULT_WIDTH-1:0] data_reg;
    logic [RESULT_WIDTH-1:0] pend_data;
    logic pend_valid;
    logic word_read_tgl;
    logic rd_s1;
    logic rd_s2;
    logic rd_s3;
    logic word_read;
    logic [RESULT_WIDTH-1:0] snap;
    logic [RESULT_WIDTH-1:0] shift_reg;
    logic [4:0] bit_cnt;
    logic cs_rst;

    // The reset pin comes from outside, so it is synchronised first.
    always_ff @(posedge i_core_clk) begin
        rst_pin_s1 <= i_reset_n_pin;
        rst_pin_s2 <= rst_pin_s1;
    end
    assign soft_reset = i_reset | ~rst_pin_s2;

    // Master-clock edges are sampled to count the pre-update hold time.
    always_ff @(posedge i_core_clk) begin
        mclk_s1 <= i_mclk_in;
        mclk_s2 <= mclk_s1;
        mclk_s3 <= mclk_s2;
    end
    assign mclk_rise = mclk_s2 & ~mclk_s3;

    // Forwarded clock is a plain inversion; gating is combinational so no edge is delayed.
    assign o_mclk_out = ~i_mclk_in;
    assign o_mclk_out_en = ~i_clock_output_disable;

    // Word-read events from the serial domain arrive as a toggle.
    always_ff @(posedge i_core_clk) begin
        rd_s1 <= word_read_tgl;
        rd_s2 <= rd_s1;
        rd_s3 <= rd_s2;
    end
    assign word_read = rd_s2 ^ rd_s3;

    // A new result that cannot land at once waits here; a later one replaces it.
    always_ff @(posedge i_core_clk) begin
        if (soft_reset) begin
            pend_valid <= 1'b0;
            pend_data <= RESULT_RST;
        end else if (i_result_valid) begin
            pend_valid <= 1'b1;
            pend_data <= i_result;
        end else if (next_state == SDR_READY && state != SDR_READY) begin
            pend_valid <= 1'b0;
        end
    end

    // Ready flag state machine.
    always_comb begin
        next_state = state;
        case (state)
            SDR_IDLE: begin
                if (pend_valid || i_cal_done) begin
                    next_state = SDR_READY;
                end
            end
            SDR_READY: begin
                if (word_read) begin
                    next_state = SDR_IDLE;
                end else if (pend_valid) begin
                    next_state = SDR_HOLD;
                end
            end
            SDR_HOLD: begin
                if (hold_cnt == MCLK_CNT_W'(PRE_UPDATE_PERIODS - 1) && mclk_rise) begin
                    next_state = SDR_READY;
                end
            end
            default: begin
                next_state = SDR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (soft_reset) begin
            state <= SDR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Counts master-clock periods while the flag is held high ahead of the update.
    always_ff @(posedge i_core_clk) begin
        if (soft_reset || state != SDR_HOLD) begin
            hold_cnt <= '0;
        end else if (mclk_rise) begin
            hold_cnt <= hold_cnt + MCLK_CNT_W'(1);
        end
    end

    // Data register loads only as the flag falls, never while the host may read it.
    always_ff @(posedge i_core_clk) begin
        if (soft_reset) begin
            data_reg <= RESULT_RST;
        end else if (next_state == SDR_READY && state != SDR_READY && pend_valid) begin
            data_reg <= pend_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (soft_reset) begin
            o_result_ready_n <= 1'b1;
            o_update_pending <= 1'b0;
        end else begin
            o_result_ready_n <= (next_state != SDR_READY);
            // Pending means waiting to load, so it clears on the edge the flag falls.
            o_update_pending <= pend_valid && (next_state != SDR_READY);
        end
    end

    // Snapshot for the serial domain, taken on the edge at which the flag falls.
    // It then stands still for as long as the flag stays low.
    always_ff @(posedge i_core_clk) begin
        if (soft_reset) begin
            snap <= RESULT_RST;
        end else if (next_state == SDR_READY && state != SDR_READY) begin
            snap <= pend_valid ? pend_data : data_reg;
        end
    end

    // Serial side: chip select high idles the shifter; the host relies on it only when ready.
    assign cs_rst = i_chip_select_n;

    // Shift out MSB first on falling edges; a full word flips the read toggle.
    // Chip select high clears the shifter at once, because the host clock
    // stands still between frames and could not do it.
    // The snapshot is read across domains without a handshake: it only changes
    // as the flag falls, and the host starts a frame only while the flag is low.
    // Limitation: a host that ignores the flag may catch a word mid-change.
    always_ff @(negedge i_serial_clk or posedge i_chip_select_n) begin
        if (i_chip_select_n) begin
            bit_cnt <= BIT_CNT_RST;
            shift_reg <= RESULT_RST;
        end else if (bit_cnt == BIT_CNT_RST) begin
            shift_reg <= {snap[RESULT_WIDTH-2:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
        end else if (bit_cnt != 5'(RESULT_WIDTH)) begin
            shift_reg <= {shift_reg[RESULT_WIDTH-2:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge i_serial_clk) begin
        if (i_reset) begin
            word_read_tgl <= 1'b0;
        end else if (!cs_rst && bit_cnt == 5'(RESULT_WIDTH - 1)) begin
            word_read_tgl <= ~word_read_tgl;
        end
    end

    // The first bit stands on the pin as soon as chip select falls, before any
    // serial edge, so the host can sample it on its first rising edge.
    assign o_serial_out = (bit_cnt == BIT_CNT_RST) ? snap[RESULT_WIDTH-1]
                                                   : shift_reg[RESULT_WIDTH-1];
    // The output is driven for the whole frame, whatever the flag shows.
    assign o_serial_out_en = ~i_chip_select_n;
endmodule : sdr_ready_port

// [verif/sdr_ready_port_sva.sv]
// Port checks for the result-ready block.
`timescale 1ns/100ps
module sdr_ready_port_sva (
    input wire logic i_core_clk, i_reset, i_reset_n_pin, i_mclk_in,
    input wire logic i_clock_output_disable, i_result_valid, i_cal_done,
    input wire logic i_serial_clk, i_chip_select_n, o_mclk_out, o_mclk_out_en,
    input wire logic o_result_ready_n, o_serial_out_en, o_update_pending
);
    logic sclk_q, cs_q;
    logic [4:0] bits;
    // Count host clock rises; the count lives one cycle past the select rising.
    always_ff @(posedge i_core_clk) begin
        sclk_q <= i_serial_clk;
        cs_q <= i_chip_select_n;
        if (i_chip_select_n && cs_q) bits <= 5'h00;
        else if (i_serial_clk && !sclk_q) bits <= bits + 5'h01;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset || !i_reset_n_pin);
    AST_MCLK_INV: assert property (o_mclk_out == !i_mclk_in)
        else $error("clock out not inverted");
    AST_MCLK_EN: assert property (o_mclk_out_en == !i_clock_output_disable)
        else $error("clock out enable wrong");
    AST_SOUT_EN: assert property (o_serial_out_en == !i_chip_select_n)
        else $error("serial out enable wrong");
    AST_READY_FALL: assert property (
        o_result_ready_n && !o_update_pending && i_result_valid |-> ##[1:2] !o_result_ready_n)
        else $error("ready not low after result");
    AST_CAL: assert property (
        o_result_ready_n && !o_update_pending && i_cal_done |-> ##[1:2] !o_result_ready_n)
        else $error("ready not low after calibration");
    AST_HOLD: assert property (o_update_pending |-> o_result_ready_n)
        else $error("ready low during update");
    AST_LOW_AFTER: assert property (
        $fell(o_update_pending) |-> ##[0:2] !o_result_ready_n)
        else $error("ready not low after update");
    AST_READ_CLEAR: assert property (
        $rose(i_chip_select_n) && bits == 5'h10 |-> ##[0:8] o_result_ready_n)
        else $error("ready not high after read");
endmodule : sdr_ready_port_sva
bind sdr_ready_port sdr_ready_port_sva u_sdr_ready_port_sva (.*);

// [verif/sdr_host_model.sv]
// Serial host that reads result words from the port.
`timescale 1ns/100ps
module sdr_host_model (
    input wire logic i_result_ready_n,
    input wire logic i_serial_out,
    output logic o_serial_clk,
    output logic o_chip_select_n
);
    // The clock idles low and stands still between frames.
    initial begin
        o_serial_clk = 1'b0;
        o_chip_select_n = 1'b1;
    end
    // Idle clocks with select high, so the read toggle takes its reset value.
    task automatic tick();
        repeat (4) begin
            #40 o_serial_clk = 1'b1;
            #40 o_serial_clk = 1'b0;
        end
    endtask : tick
    // One word, MSB first, sampled on rising edges.
    task automatic read_word(output logic [15:0] w);
        wait (i_result_ready_n === 1'b0);
        o_chip_select_n = 1'b0;
        repeat (16) begin
            #40 o_serial_clk = 1'b1;
            w = {w[14:0], i_serial_out};
            #40 o_serial_clk = 1'b0;
        end
        #40 o_chip_select_n = 1'b1;
    endtask : read_word
endmodule : sdr_host_model

// [verif/tb_sdr_ready_port.sv]
// Testbench for the result-ready port.
`timescale 1ns/100ps
module tb_sdr_ready_port;
    import sdr_pkg::*;
    localparam int PRE = 4;
    logic clk = 1'b0, rst = 1'b1, rpin = 1'b1, mclk = 1'b0, dis = 1'b0, vld = 1'b0;
    logic cal = 1'b0, prev;
    logic [15:0] res = 16'h0000, got;
    logic sclk, cs_n, mo, men, rdy_n, so, soe, pend;
    int n_errors = 0, n_tests = 0, cyc = 0, cnt;
    // Model of the data register: every word sent, newest last.
    int exp_q[$];
    int unsigned seed = 70;
    always #12.5 clk = ~clk;
    always #200 mclk = ~mclk;
    sdr_ready_port #(.PRE_UPDATE_PERIODS(PRE)) u_sdr_ready_port (.i_core_clk(clk),
        .i_reset(rst), .i_reset_n_pin(rpin), .i_mclk_in(mclk), .i_clock_output_disable(dis),
        .i_result_valid(vld), .i_result(res), .i_cal_done(cal), .i_serial_clk(sclk),
        .i_chip_select_n(cs_n), .o_mclk_out(mo), .o_mclk_out_en(men),
        .o_result_ready_n(rdy_n), .o_serial_out(so), .o_serial_out_en(soe),
        .o_update_pending(pend));
    sdr_host_model u_sdr_host_model (.i_result_ready_n(rdy_n), .i_serial_out(so),
        .o_serial_clk(sclk), .o_chip_select_n(cs_n));
    function automatic int unsigned xs(int unsigned x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // One-cycle pulse of a result or a calibration end; the model keeps the word.
    task automatic send(bit c);
        @(negedge clk);
        seed = xs(seed);
        if (c) cal = 1'b1;
        else begin
            vld = 1'b1;
            res = seed[15:0];
            exp_q.push_back(int'(seed[15:0]));
        end
        @(negedge clk);
        vld = 1'b0;
        cal = 1'b0;
        repeat (3) @(negedge clk);
    endtask : send
    // A word superseded before it was read is lost; the newest one must arrive.
    task automatic rd();
        u_sdr_host_model.read_word(got);
        while (exp_q.size() > 1) void'(exp_q.pop_front());
        check(got, exp_q[0][15:0]);
        repeat (10) @(negedge clk);
        check(rdy_n, 16'h0001);
    endtask : rd
    // A hang is cut short well past the several hundred cycles the run needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        fork u_sdr_host_model.tick(); join_none
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        check({rdy_n, pend}, 16'h0002);
        for (int k = 0; k < 3; k++) begin
            send(1'b0);
            check(rdy_n, 16'h0000);
            rd();
        end
        $display("test reads done");
        send(1'b0);
        send(1'b0);
        check(rdy_n, 16'h0001);
        cnt = 0;
        prev = mclk;
        repeat (200) begin
            @(negedge clk);
            if (rdy_n) cnt += (mclk && !prev);
            prev = mclk;
        end
        check(cnt >= PRE - 1 && cnt <= PRE + 1, 16'h0001);
        check(rdy_n, 16'h0000);
        rd();
        $display("test unread done");
        send(1'b1);
        check(rdy_n, 16'h0000);
        rd();
        for (int k = 0; k < 4; k++) begin
            dis = k[0];
            @(negedge clk);
            check(men, !dis);
            check(mo, !mclk);
        end
        send(1'b0);
        rpin = 1'b0;
        repeat (4) @(negedge clk);
        rpin = 1'b1;
        repeat (4) @(negedge clk);
        check(rdy_n, 16'h0001);
        // The word sent before the pin reset is gone; the port must work again.
        exp_q.delete();
        send(1'b0);
        check(rdy_n, 16'h0000);
        rd();
        $display("test misc done");
        summarize();
    end
endmodule : tb_sdr_ready_port
